// [rtl/data_space_pkg.sv]
// Constants for the lower data space decoder and the core register block.
package data_space_pkg;
	localparam int addr_w = 16;
	localparam int data_w = 16;
	localparam int num_work_regs = 15;
	localparam logic [15:0] near_base = 16'h0000;
	localparam logic [15:0] near_last = 16'h1fff;
	localparam logic [15:0] sfr_base = 16'h0000;
	localparam logic [15:0] sfr_last = 16'h07ff;
	localparam logic [15:0] ram_last = 16'h1fff;
	localparam int near_field_w = 13;
	localparam int full_field_w = 16;
	localparam int block_lsb = 5;
	localparam int block_msb = 10;
	localparam int num_blocks = 64;
	localparam logic [15:0] work_reg_base = 16'h0000;
	localparam logic [15:0] work_reg_last = 16'h001d;
	localparam logic [15:0] work_reg_reset = 16'h0000;
	localparam int psv_bit = 15;
	// One bit per 32-byte block of the register area; bit n covers n*32.
	localparam logic [63:0] impl_block_map = {
		8'b0000_1100, 8'b1111_0111, 8'b0000_0000, 8'b0000_0000,
		8'b0000_0011, 8'b1100_1111, 8'b0001_0111, 8'b0011_1111};
	typedef enum logic [2:0] {
		mode_near_direct = 3'b001,
		mode_full_direct = 3'b010,
		mode_indirect = 3'b100
	} addr_mode_e;
endpackage

// [rtl/data_space_sfr_decoder.sv]
// Lower data space decoder with the core working register block.
`timescale 1ns/1ps
module data_space_sfr_decoder
	import data_space_pkg::*;
#(
	parameter int ram_words = 4096
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire data_space_pkg::addr_mode_e rd_mode_in,
	input wire logic [15:0] rd_field_in,
	input wire logic rd_en_in,
	input wire logic rd_byte_in,
	input wire data_space_pkg::addr_mode_e wr_mode_in,
	input wire logic [15:0] wr_field_in,
	input wire logic wr_en_in,
	input wire logic wr_byte_in,
	input wire logic [15:0] wr_data_in,
	input wire logic [15:0] periph_rdata_in,
	output logic [15:0] rd_data_out,
	output logic rd_valid_out,
	output logic rd_psv_out,
	output logic [15:0] rd_addr_out,
	output logic [5:0] periph_block_out,
	output logic periph_rd_sel_out,
	output logic periph_wr_sel_out,
	output logic [15:0] periph_addr_out,
	output logic [15:0] periph_wdata_out,
	output logic periph_wr_byte_out
);
	import data_space_pkg::*;

	logic [15:0] work_q [num_work_regs];
	logic [15:0] ram_q [ram_words];
	logic [15:0] rd_ea;
	logic [15:0] wr_ea;
	logic rd_near, rd_sfr, rd_ram, rd_psv, rd_impl;
	logic wr_near, wr_sfr, wr_ram, wr_psv, wr_impl;
	logic [5:0] rd_blk;
	logic [15:0] rd_data_d;
	logic [15:0] rd_word;

	// Forms the effective address from the instruction field or register.
	function automatic logic [15:0] form_ea(input addr_mode_e m,
		input logic [15:0] f);
		logic [15:0] r;
		r = f;
		unique case (m)
			mode_near_direct: r = {3'h0, f[near_field_w-1:0]};
			mode_full_direct: r = f[full_field_w-1:0];
			mode_indirect: r = f;
			default: r = f;
		endcase
		return r;
	endfunction

	// True when the address hits a working register slot.
	function automatic logic is_work(input logic [15:0] a);
		return a >= work_reg_base && a <= work_reg_last;
	endfunction

	function automatic logic [3:0] work_idx(input logic [15:0] a);
		return a[4:1];
	endfunction

	assign rd_ea = form_ea(rd_mode_in, rd_field_in);
	assign wr_ea = form_ea(wr_mode_in, wr_field_in);

	sfr_block_decoder u_rd_dec (
		.addr_in(rd_ea),
		.in_near_out(rd_near),
		.in_sfr_out(rd_sfr),
		.in_ram_out(rd_ram),
		.psv_out(rd_psv),
		.block_impl_out(rd_impl),
		.block_out(rd_blk)
	);

	sfr_block_decoder u_wr_dec (
		.addr_in(wr_ea),
		.in_near_out(wr_near),
		.in_sfr_out(wr_sfr),
		.in_ram_out(wr_ram),
		.psv_out(wr_psv),
		.block_impl_out(wr_impl),
		.block_out()
	);

	// Peripheral selects go out only for populated register blocks.
	always_comb begin
		periph_block_out = rd_blk;
		periph_rd_sel_out = rd_en_in && rd_impl && !is_work(rd_ea);
		periph_wr_sel_out = wr_en_in && wr_impl && !is_work(wr_ea);
		periph_addr_out = periph_wr_sel_out ? wr_ea : rd_ea;
		periph_wdata_out = wr_data_in;
		periph_wr_byte_out = wr_byte_in;
	end

	// Working registers with byte lanes; low byte lives at the even address.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < num_work_regs; i++) begin
				work_q[i] <= work_reg_reset;
			end
		end else if (wr_en_in && !wr_psv && is_work(wr_ea)) begin
			if (work_idx(wr_ea) < 4'(num_work_regs)) begin
				if (!wr_byte_in) begin
					work_q[work_idx(wr_ea)] <= wr_data_in;
				end else if (wr_ea[0]) begin
					work_q[work_idx(wr_ea)][15:8] <= wr_data_in[7:0];
				end else begin
					work_q[work_idx(wr_ea)][7:0] <= wr_data_in[7:0];
				end
			end
		end
	end

	// General data memory above the register area, up to the 8 KB limit.
	always_ff @(posedge clk_in) begin
		if (wr_en_in && wr_ram && wr_near && !wr_sfr) begin
			if (!wr_byte_in) begin
				ram_q[wr_ea[12:1]] <= wr_data_in;
			end else if (wr_ea[0]) begin
				ram_q[wr_ea[12:1]][15:8] <= wr_data_in[7:0];
			end else begin
				ram_q[wr_ea[12:1]][7:0] <= wr_data_in[7:0];
			end
		end
	end

	// Read word selection; anything unmapped yields zero.
	always_comb begin
		rd_word = 16'h0000;
		if (rd_psv) begin
			rd_word = 16'h0000;
		end else if (rd_sfr) begin
			if (is_work(rd_ea) && work_idx(rd_ea) < 4'(num_work_regs)) begin
				rd_word = work_q[work_idx(rd_ea)];
			end else if (rd_impl) begin
				rd_word = periph_rdata_in;
			end else begin
				rd_word = 16'h0000;
			end
		end else if (rd_ram && rd_near) begin
			rd_word = ram_q[rd_ea[12:1]];
		end
		rd_data_d = rd_word;
		if (rd_byte_in) begin
			rd_data_d = {8'h00, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]};
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_data_out <= 16'h0000;
			rd_valid_out <= 1'b0;
			rd_psv_out <= 1'b0;
			rd_addr_out <= 16'h0000;
		end else begin
			rd_valid_out <= rd_en_in;
			rd_psv_out <= rd_en_in && rd_psv;
			if (rd_en_in) begin
				rd_data_out <= rd_data_d;
				rd_addr_out <= rd_ea;
			end
		end
	end
endmodule

// [rtl/sfr_block_decoder.sv]
// Decoder that classifies a byte address inside the lower data space.
`timescale 1ns/1ps
module sfr_block_decoder
	import data_space_pkg::*;
(
	input wire logic [15:0] addr_in,
	output logic in_near_out,
	output logic in_sfr_out,
	output logic in_ram_out,
	output logic psv_out,
	output logic block_impl_out,
	output logic [5:0] block_out
);
	always_comb begin
		block_out = addr_in[block_msb:block_lsb];
		psv_out = addr_in[psv_bit];
		in_near_out = addr_in <= near_last;
		in_sfr_out = addr_in <= sfr_last;
		in_ram_out = !addr_in[psv_bit] && addr_in <= ram_last;
		block_impl_out = in_sfr_out && impl_block_map[block_out];
	end
endmodule

// [tb/ds_sva.sv]
// Port checker for the lower data space decoder.
`timescale 1ns/1ps
module ds_sva
	import data_space_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire data_space_pkg::addr_mode_e rd_mode_in,
	input wire logic [15:0] rd_field_in,
	input wire logic rd_en_in,
	input wire logic [15:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic rd_psv_out,
	input wire logic [15:0] rd_addr_out,
	input wire logic [5:0] periph_block_out,
	input wire logic periph_rd_sel_out
);
	logic [12:0] f_q;
	always_ff @(posedge clk_in) begin
		f_q <= rd_field_in[12:0];
	end
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	sequence ind_rd;
		rd_en_in && rd_mode_in == mode_indirect;
	endsequence
	AST_VALID: assert property (rd_en_in |=> rd_valid_out)
		else $error("read not answered");
	AST_IDLE: assert property (!rd_en_in |=> !rd_valid_out)
		else $error("answer without read");
	AST_PSV: assert property (ind_rd ##0 rd_field_in[15]
		|=> rd_psv_out && rd_data_out == 16'h0000) else $error("psv read");
	AST_FAR: assert property (ind_rd ##0 rd_field_in[15:13] != 3'h0
		|=> rd_data_out == 16'h0000) else $error("far read not zero");
	AST_EMPTY: assert property (ind_rd ##0 (rd_field_in[15:11] == 5'h00
		&& !impl_block_map[rd_field_in[10:5]]) |=> rd_data_out == 16'h0000)
		else $error("empty block not zero");
	AST_BLK: assert property (periph_block_out == rd_field_in[10:5])
		else $error("block select bits");
	AST_SEL: assert property (periph_rd_sel_out
		|-> impl_block_map[periph_block_out]) else $error("select on empty");
	AST_NEAR: assert property (rd_en_in && rd_mode_in == mode_near_direct
		|=> rd_addr_out == {3'h0, f_q}) else $error("near address");
endmodule
bind data_space_sfr_decoder ds_sva i_sva(.*);

// [tb/periph_model.sv]
// Peripheral register model answering reads on the peripheral select.
`timescale 1ns/1ps
module periph_model (
	input wire logic sel_in,
	input wire logic [15:0] addr_in,
	output logic [15:0] rdata_out
);
	// An unselected bus shows a pattern that tracks the address, not zero.
	assign rdata_out = sel_in ? addr_in ^ 16'h5a5a : ~addr_in;
endmodule

// [tb/test_data_space_sfr_decoder.sv]
// Directed regression for the lower data space decoder.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_data_space_sfr_decoder;
	import data_space_pkg::*;
	logic clk_in = 1'h0, srst_in = 1'h1, rd_en_in = 1'h0, rd_byte_in = 1'h0;
	logic wr_en_in = 1'h0, wr_byte_in = 1'h0;
	addr_mode_e rd_mode_in = mode_indirect, wr_mode_in = mode_indirect;
	logic [15:0] rd_field_in = 16'h0000, wr_field_in = 16'h0000;
	logic [15:0] wr_data_in = 16'h0000, periph_rdata_in, rd_data_out;
	logic [15:0] rd_addr_out, periph_addr_out, periph_wdata_out;
	logic rd_valid_out, rd_psv_out, periph_rd_sel_out, periph_wr_sel_out;
	logic periph_wr_byte_out;
	logic [5:0] periph_block_out;
	int fails = 0, checks = 0, cyc = 0;
	always #2.5 clk_in = ~clk_in;
	data_space_sfr_decoder i_dut(.*);
	periph_model i_periph(.sel_in(periph_rd_sel_out),
		.addr_in(periph_addr_out), .rdata_out(periph_rdata_in));
	task wr(addr_mode_e m, logic [15:0] a, logic [15:0] d, logic b,
		logic sel);
		@(posedge clk_in);
		wr_mode_in <= m;
		wr_field_in <= a;
		wr_data_in <= d;
		wr_byte_in <= b;
		wr_en_in <= 1'h1;
		#1;
		`CHK("periph_wr_sel_out", sel, periph_wr_sel_out)
		`CHK("periph_wdata_out", d, periph_wdata_out)
		`CHK("periph_wr_byte_out", b, periph_wr_byte_out)
		if (sel) `CHK("periph_addr_out", a, periph_addr_out)
		@(posedge clk_in);
		wr_en_in <= 1'h0;
	endtask
	task rd(addr_mode_e m, logic [15:0] a, logic b, logic [15:0] e);
		@(posedge clk_in);
		rd_mode_in <= m;
		rd_field_in <= a;
		rd_byte_in <= b;
		rd_en_in <= 1'h1;
		@(posedge clk_in);
		rd_en_in <= 1'h0;
		#1;
		`CHK("rd_valid_out", 1'h1, rd_valid_out)
		`CHK("rd_data_out", e, rd_data_out)
	endtask
	task results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge clk_in);
		srst_in <= 1'h0;
		for (int i = 0; i < num_work_regs; i++) begin
			rd(mode_indirect, 16'(2 * i), 1'h0, work_reg_reset);
		end
		$display("test reset done");
		wr(mode_near_direct, 16'h0006, 16'h1234, 1'h0, 1'h0);
		rd(mode_full_direct, 16'h0006, 1'h0, 16'h1234);
		rd(mode_near_direct, 16'he006, 1'h0, 16'h1234);
		rd(mode_indirect, 16'h0007, 1'h1, 16'h0012);
		wr(mode_indirect, 16'h0007, 16'h00ab, 1'h1, 1'h0);
		rd(mode_indirect, 16'h0006, 1'h0, 16'hab34);
		wr(mode_indirect, 16'h1ffe, 16'hbeef, 1'h0, 1'h0);
		wr(mode_indirect, 16'h1ffe, 16'h0077, 1'h1, 1'h0);
		rd(mode_full_direct, 16'h1ffe, 1'h0, 16'hbe77);
		wr(mode_indirect, 16'h0202, 16'h9abc, 1'h0, 1'h1);
		$display("test memory done");
		@(posedge clk_in);
		srst_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'h0;
		#1;
		`CHK("rd_valid_out", 1'h0, rd_valid_out)
		`CHK("rd_data_out", 16'h0000, rd_data_out)
		rd(mode_indirect, 16'h0006, 1'h0, work_reg_reset);
		$display("test second reset done");
		rd(mode_indirect, 16'h0100, 1'h0, 16'h0100 ^ 16'h5a5a);
		wr(mode_indirect, 16'h0400, 16'h5555, 1'h0, 1'h0);
		rd(mode_indirect, 16'h0400, 1'h0, 16'h0000);
		rd(mode_indirect, 16'h05e0, 1'h0, 16'h0000);
		rd(mode_indirect, 16'h00e0, 1'h0, 16'h0000);
		rd(mode_indirect, 16'h2000, 1'h0, 16'h0000);
		rd(mode_indirect, 16'h8000, 1'h0, 16'h0000);
		`CHK("rd_psv_out", 1'h1, rd_psv_out)
		$display("test map done");
		results();
	end
endmodule
